// *** hw/clkmac_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module clkmac_top #(
  parameter int unsigned LONG_CYC = clkmac_pkg::LONG_PRESS_CYC
) (
  input  wire logic                 mclk,
  input  wire logic                 reset_n,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic [31:0]               hrdata,
  input  wire logic                 keyFwdPin,
  input  wire logic                 keyBackPin,
  input  wire logic                 keyPlusPin,
  input  wire logic                 keyMinusPin,
  input  wire logic [4:0]           curHour,
  input  wire logic [5:0]           curMinute,
  input  wire logic [2:0]           curWeekday,
  input  wire logic                 minuteTick,
  input  wire logic                 altTick,
  input  wire logic                 syncActive,
  input  wire logic                 rxSignal,
  input  wire logic                 tempOk,
  output clkmac_pkg::clkmac_view_t  viewSel,
  output logic                      dpOn,
  output clkmac_pkg::clkmac_menu_t  menuItem,
  output logic                      fullBright,
  output logic                      buzzer,
  output logic                      calTempStart,
  output logic                      calOffsetStart
);
  import clkmac_pkg::*;
  localparam int CW = $clog2(LONG_CYC + 1);

  // ****************************************
  // Key synchronisers and press detection
  // ****************************************
  logic [3:0] s1_r, s2_r, s3_r, keyLvl_r, press;
  logic [CW-1:0] holdCnt_r;
  logic       longDone_r;
  logic       evFwd, evBack, evPlus, evMinus, evLongPlus, evLongMinus, pmHeld;
  assign press  = (s2_r ~^ s3_r) & s3_r & ~keyLvl_r;
  assign evFwd  = press[0];
  assign evBack = press[1];
  assign pmHeld = keyLvl_r[2] | keyLvl_r[3];
  // Short plus/minus fire on release so a long hold is not also a short press
  assign evPlus      = keyLvl_r[2] & (s2_r[2] == s3_r[2]) & ~s3_r[2] & ~longDone_r;
  assign evMinus     = keyLvl_r[3] & (s2_r[3] == s3_r[3]) & ~s3_r[3] & ~longDone_r;
  assign evLongPlus  = keyLvl_r[2] & ~longDone_r & (holdCnt_r == CW'(LONG_CYC - 1));
  assign evLongMinus = keyLvl_r[3] & ~keyLvl_r[2] & ~longDone_r
                       & (holdCnt_r == CW'(LONG_CYC - 1));

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      s1_r <= 4'h0;
      s2_r <= 4'h0;
      s3_r <= 4'h0;
      keyLvl_r <= 4'h0;
    end else begin
      s1_r <= {keyMinusPin, keyPlusPin, keyBackPin, keyFwdPin};
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < 4; i++) begin
        if (s2_r[i] == s3_r[i]) keyLvl_r[i] <= s3_r[i];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n || !pmHeld) begin
      holdCnt_r <= '0;
      longDone_r <= 1'b0;
    end else if (evLongPlus || evLongMinus) begin
      longDone_r <= 1'b1;
    end else if (!longDone_r) begin
      holdCnt_r <= holdCnt_r + CW'(1);
    end
  end

  // ****************************************
  // Register bus
  // ****************************************
  logic       wrPend_r, regWr;
  logic [7:0] wrAddr_r;
  logic [1:0] dispMode_r;
  logic       tempEn_r, armed_r, flash_r;
  logic [4:0] recvBright_r, alHour_r, alSnooze_r;
  logic [5:0] alMinute_r, alMaxTime_r;
  logic [3:0] alDelay_r, daySel_r;
  logic [6:0] dayEn_r;
  logic       weekGrp_r, wkndGrp_r;
  clkmac_alarm_t alState_r;
  clkmac_menu_t  menu_r;
  logic [31:0] rdMux;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign regWr     = wrPend_r;

  always_comb begin
    rdMux = 32'h0;
    unique case (haddr[7:0])
      ADDR_CTRL: begin
        rdMux[1:0] = dispMode_r;
        rdMux[CTRL_TEMP] = tempEn_r;
        rdMux[CTRL_BRT +: 5] = recvBright_r;
        rdMux[CTRL_ARM] = armed_r;
      end
      ADDR_ALARM: begin
        rdMux[4:0] = alHour_r;
        rdMux[AL_MIN +: 6] = alMinute_r;
        rdMux[AL_SNZ +: 5] = alSnooze_r;
        rdMux[AL_DLY +: 4] = alDelay_r;
      end
      ADDR_ALARM2: begin
        rdMux[5:0] = alMaxTime_r;
        rdMux[AL2_DAY +: 7] = dayEn_r;
        rdMux[AL2_WEEK] = weekGrp_r;
        rdMux[AL2_WKND] = wkndGrp_r;
      end
      ADDR_STATUS: begin
        rdMux[3:0] = menu_r;
        rdMux[ST_RING] = (alState_r == AL_RING);
        rdMux[ST_SNZ] = (alState_r == AL_SNOOZE);
        rdMux[ST_BUZ] = buzzer;
        rdMux[ST_FULL] = fullBright;
        rdMux[ST_DAY +: 4] = daySel_r;
      end
      default: rdMux = 32'h0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      wrPend_r <= 1'b0;
      wrAddr_r <= 8'h0;
      hrdata <= 32'h0;
    end else begin
      wrPend_r <= hsel & hready & htrans[1] & hwrite;
      if (hsel && hready && htrans[1]) begin
        wrAddr_r <= haddr[7:0];
        if (!hwrite) hrdata <= rdMux;
      end
    end
  end

  // ****************************************
  // Menu navigation
  // ****************************************
  logic keysFree;
  assign keysFree   = (alState_r == AL_IDLE);
  assign menuItem   = menu_r;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      menu_r <= CM_CLOSED;
    end else if (keysFree) begin
      if (evFwd) begin // [RULE3]
        unique case (menu_r)
          CM_CLOSED:   menu_r <= CM_DISPMODE;
          CM_ALARM:    menu_r <= CM_MENUEND;
          CM_AEXIT:    menu_r <= CM_DAYSEL;
          CM_MENUEND:  menu_r <= CM_CLOSED;
          default:     menu_r <= clkmac_menu_t'(menu_r + 4'h1);
        endcase
      end else if (evBack) begin // [RULE3]
        unique case (menu_r)
          CM_CLOSED:   menu_r <= CM_MENUEND;
          CM_DISPMODE: menu_r <= CM_CLOSED;
          CM_DAYSEL:   menu_r <= CM_AEXIT;
          CM_MENUEND:  menu_r <= CM_ALARM;
          default:     menu_r <= clkmac_menu_t'(menu_r - 4'h1);
        endcase
      end else if (evPlus && menu_r == CM_ALARM) begin
        menu_r <= CM_DAYSEL; // [RULE4]
      end else if (evPlus && menu_r == CM_AEXIT) begin
        menu_r <= CM_ALARM; // [RULE4]
      end
    end
  end

  // ****************************************
  // Settings edited by keys or bus
  // ****************************************
  logic selGrp, selOn, daySelEditable;
  assign selGrp = (daySel_r >= 4'(SAT_IDX)) ? wkndGrp_r : weekGrp_r;
  assign selOn  = (daySel_r == SEL_WEEK) ? weekGrp_r :
                  (daySel_r == SEL_WKND) ? wkndGrp_r : (selGrp | dayEn_r[daySel_r[2:0]]);
  assign daySelEditable = (daySel_r > DAYS_LAST) || !selGrp; // [RULE14]

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      dispMode_r <= MODE_ALTERNATING_VIEW;
      tempEn_r <= 1'b0;
      recvBright_r <= BRT_RST;
      armed_r <= 1'b0;
      flash_r <= 1'b0;
      alHour_r <= 5'h0;
      alMinute_r <= 6'h0;
      alSnooze_r <= SNZ_RST;
      alDelay_r <= 4'h0;
      alMaxTime_r <= MAXT_RST;
      dayEn_r <= 7'h0;
      weekGrp_r <= 1'b0;
      wkndGrp_r <= 1'b0;
      daySel_r <= 4'h0;
    end else if (regWr) begin
      unique case (wrAddr_r)
        ADDR_CTRL: begin
          dispMode_r <= hwdata[1:0];
          tempEn_r <= hwdata[CTRL_TEMP];
          recvBright_r <= hwdata[CTRL_BRT +: 5];
          armed_r <= hwdata[CTRL_ARM];
        end
        ADDR_ALARM: begin
          alHour_r <= hwdata[4:0];
          alMinute_r <= hwdata[AL_MIN +: 6];
          alSnooze_r <= hwdata[AL_SNZ +: 5];
          alDelay_r <= hwdata[AL_DLY +: 4];
        end
        ADDR_ALARM2: begin
          alMaxTime_r <= hwdata[5:0];
          dayEn_r <= hwdata[AL2_DAY +: 7];
          weekGrp_r <= hwdata[AL2_WEEK];
          wkndGrp_r <= hwdata[AL2_WKND];
        end
        default: ;
      endcase
    end else if (keysFree) begin
      unique case (menu_r)
        CM_CLOSED: begin
          if (evPlus) armed_r <= ~armed_r; // [RULE8]
          if (evMinus) flash_r <= ~flash_r; // [RULE9]
        end
        CM_DISPMODE: begin // [RULE10] [RULE7]
          if (evPlus) dispMode_r <= dispMode_r + 2'h1;
          if (evMinus) dispMode_r <= dispMode_r - 2'h1;
        end
        CM_SHOWTEMP: begin // [RULE13] [RULE6]
          if (evPlus) tempEn_r <= 1'b1;
          if (evMinus) tempEn_r <= 1'b0;
        end
        CM_DAYSEL: begin // [RULE7] [RULE14]
          if (evPlus) daySel_r <= (daySel_r == SEL_WKND) ? 4'h0 : daySel_r + 4'h1;
          if (evMinus) daySel_r <= (daySel_r == 4'h0) ? SEL_WKND : daySel_r - 4'h1;
          if ((evLongPlus || evLongMinus) && daySelEditable) begin
            if (daySel_r == SEL_WEEK) weekGrp_r <= evLongPlus;
            else if (daySel_r == SEL_WKND) wkndGrp_r <= evLongPlus;
            else dayEn_r[daySel_r[2:0]] <= evLongPlus;
          end
        end
        CM_ENABLE: begin // [RULE16] [RULE6]
          if (evPlus) armed_r <= 1'b1;
          if (evMinus) armed_r <= 1'b0;
        end
        CM_HOUR: begin // [RULE5]
          if (evPlus && alHour_r < HOUR_MAX) alHour_r <= alHour_r + 5'h1;
          if (evMinus && alHour_r != 5'h0) alHour_r <= alHour_r - 5'h1;
        end
        CM_MINUTE: begin // [RULE17] [RULE5]
          if (evPlus && alMinute_r < MIN_MAX) alMinute_r <= alMinute_r + 6'h1;
          if (evMinus && alMinute_r != 6'h0) alMinute_r <= alMinute_r - 6'h1;
        end
        CM_SNOOZE: begin // [RULE18]
          if (evPlus && alSnooze_r < SNZ_MAX) alSnooze_r <= alSnooze_r + 5'h1;
          if (evMinus && alSnooze_r > SNZ_MIN) alSnooze_r <= alSnooze_r - 5'h1;
        end
        CM_DELAY: begin // [RULE20]
          if (evPlus && alDelay_r < DLY_MAX) alDelay_r <= alDelay_r + 4'h1;
          if (evMinus && alDelay_r != 4'h0) alDelay_r <= alDelay_r - 4'h1;
        end
        CM_MAXTIME: begin // [RULE22]
          if (evPlus && alMaxTime_r < MAXT_MAX) alMaxTime_r <= alMaxTime_r + 6'h1;
          if (evMinus && alMaxTime_r > MAXT_MIN) alMaxTime_r <= alMaxTime_r - 6'h1;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      calTempStart <= 1'b0;
      calOffsetStart <= 1'b0;
    end else begin
      calTempStart <= keysFree & (menu_r == CM_SHOWTEMP) & evLongPlus; // [RULE13]
      calOffsetStart <= keysFree & (menu_r == CM_SHOWTEMP) & evLongMinus; // [RULE13]
    end
  end

  // ****************************************
  // Alarm sequencing
  // ****************************************
  logic [5:0] alElapsed_r;
  logic       dayActive, alMatch, alFire;
  assign dayActive = ((curWeekday >= SAT_IDX) ? wkndGrp_r : weekGrp_r) | dayEn_r[curWeekday];
  assign alMatch   = (curHour == alHour_r) && (curMinute == alMinute_r);
  assign alFire    = minuteTick & armed_r & dayActive & alMatch; // [RULE23]

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      alState_r <= AL_IDLE;
      alElapsed_r <= 6'h0;
    end else begin
      unique case (alState_r)
        AL_IDLE: if (alFire) begin // [RULE23]
          alState_r <= AL_RING;
          alElapsed_r <= 6'h0;
        end
        AL_RING: begin
          if (evFwd || evBack) alState_r <= AL_IDLE; // [RULE19]
          else if (press[2] || press[3]) begin // [RULE19]
            alState_r <= AL_SNOOZE;
            alElapsed_r <= 6'h0;
          end else if (minuteTick) begin
            alElapsed_r <= alElapsed_r + 6'h1;
            if (alElapsed_r + 6'h1 >= alMaxTime_r) alState_r <= AL_IDLE; // [RULE23]
          end
        end
        AL_SNOOZE: begin
          if (evFwd || evBack) alState_r <= AL_IDLE; // [RULE19]
          else if (minuteTick) begin
            alElapsed_r <= alElapsed_r + 6'h1;
            if (alElapsed_r + 6'h1 >= 6'(alSnooze_r)) begin
              alState_r <= AL_RING;
              alElapsed_r <= 6'h0;
            end
          end
        end
        default: alState_r <= AL_IDLE;
      endcase
    end
  end

  // Over-long delay never sounds; brightness alone wakes
  assign buzzer = (alState_r == AL_RING) && (6'(alDelay_r) <= alMaxTime_r)
                  && (6'(alDelay_r) <= alElapsed_r); // [RULE21]
  assign fullBright = flash_r | (alState_r == AL_RING); // [RULE9] [RULE21]

  // ****************************************
  // Display content selection
  // ****************************************
  logic [1:0] phase_r, phaseNext;
  logic [2:0] viewEn;
  clkmac_view_t normView;
  assign viewEn[0] = dispMode_r[0];
  assign viewEn[1] = dispMode_r[1];
  assign viewEn[2] = tempEn_r & tempOk; // [RULE12]

  always_comb begin
    phaseNext = phase_r;
    for (int k = 2; k >= 0; k--) begin
      if (viewEn[2'((32'(phase_r) + k + 1) % 3)]) phaseNext = 2'((32'(phase_r) + k + 1) % 3);
    end
    unique case (phase_r)
      2'h0: normView = VIEW_TIME;
      2'h1: normView = VIEW_DATE;
      default: normView = VIEW_TEMP;
    endcase
    if (!viewEn[phase_r]) normView = VIEW_DASHES;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) phase_r <= 2'h0;
    else if (altTick || !viewEn[phase_r]) phase_r <= phaseNext; // [RULE12]
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      viewSel <= VIEW_BLANK;
      dpOn <= 1'b0;
    end else if (syncActive && recvBright_r == 5'h0) begin
      viewSel <= VIEW_BLANK; // [RULE2]
      dpOn <= rxSignal;
    end else if (syncActive) begin
      viewSel <= VIEW_SYNC; // [RULE1]
      dpOn <= 1'b0;
    end else if (menu_r != CM_CLOSED) begin
      viewSel <= VIEW_MENU;
      dpOn <= (menu_r == CM_DAYSEL) & selOn; // [RULE15]
    end else begin
      viewSel <= normView; // [RULE10] [RULE11]
      dpOn <= 1'b0;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  syncBlank_a: assert property (syncActive && recvBright_r == 5'h0 |=> // [RULE2]
    viewSel == VIEW_BLANK && dpOn == $past(rxSignal)) else $error("sync blank wrong");
  syncText_a: assert property (syncActive && recvBright_r != 5'h0 |=> // [RULE1]
    viewSel == VIEW_SYNC) else $error("sync text missing");
  menuOpen_a: assert property (keysFree && menu_r == CM_CLOSED && evFwd |=> // [RULE3]
    menu_r == CM_DISPMODE) else $error("menu did not open");
  subExit_a: assert property (keysFree && menu_r == CM_AEXIT && evPlus && !evFwd && !evBack
    |=> menu_r == CM_ALARM) else $error("submenu exit failed"); // [RULE4]
  snoozeFloor_a: assert property (keysFree && menu_r == CM_SNOOZE && evMinus && !regWr // [RULE18]
    && alSnooze_r == SNZ_MIN |=> alSnooze_r == SNZ_MIN) else $error("snooze below floor");
  armToggle_a: assert property (keysFree && menu_r == CM_CLOSED && evPlus && !regWr |=> // [RULE8]
    armed_r != $past(armed_r)) else $error("alarm toggle failed");
  noBuzz_a: assert property (6'(alDelay_r) > alMaxTime_r |-> !buzzer) // [RULE21]
    else $error("buzzer with over-long delay");
  alarmFire_a: assert property (alState_r == AL_IDLE && alFire |=> // [RULE23]
    alState_r == AL_RING ##0 !buzzer || alDelay_r == 4'h0) else $error("alarm not fired");
  snoozeStop_a: assert property (alState_r == AL_RING && (evFwd || evBack) |=> // [RULE19]
    alState_r == AL_IDLE) else $error("alarm not stopped");
  hiddenDash_a: assert property (!syncActive && menu_r == CM_CLOSED // [RULE11]
    && dispMode_r == MODE_CLOCK_HIDDEN && !viewEn[2] [*2] |=> viewSel == VIEW_DASHES)
    else $error("hidden mode not dashed");

  ringCov_c: cover property (alState_r == AL_IDLE ##1 alState_r == AL_RING);
  snzCov_c: cover property (alState_r == AL_RING ##1 alState_r == AL_SNOOZE);
  subCov_c: cover property (menu_r == CM_ALARM ##1 menu_r == CM_DAYSEL);
endmodule // clkmac_top
`default_nettype wire

// *** hw/clkmac_pkg.sv ***
// Operation
// [RULE1] During sync with receive brightness above zero, keep the sync text shown.
// [RULE2] During sync with receive brightness zero, blank all but one progress point.
// [RULE3] Either navigation key opens the menu; forward steps on, backward steps back.
// [RULE4] Plus enters a submenu; plus on its exit item leaves it.
// [RULE5] Numeric settings: plus increments, minus decrements, within the setting's range.
// [RULE6] On/off settings: plus sets on, minus sets off.
// [RULE7] List settings: plus advances in list order, minus steps back.
// [RULE8] Outside the menu, plus toggles the alarm armed state.
// [RULE9] Outside the menu, minus toggles forced full brightness against normal brightness.
// [RULE10] Display mode offers hidden, time only, date only, alternating, in that order.
// [RULE11] Hidden mode shows temperature if enabled and possible, else dashes.
// [RULE12] With temperature enabled, time or date content alternates with temperature.
// [RULE13] Temperature item: short press toggles display, long presses start calibrations. Code: short plus sets display on, short minus sets it off.
// [RULE14] Week and weekend groups; a day in an active group cannot be edited.
// [RULE15] During day selection a decimal point shows whether that day is active.
// [RULE16] Alarm enable: plus arms, minus disarms, label shows state.
// [RULE17] Alarm minute ranges 0 to 59.
// [RULE18] Snooze duration ranges 1 to 30 minutes.
// [RULE19] While sounding, plus or minus snoozes; a navigation key stops the alarm.
// [RULE20] Sound delay ranges 0 to 10 minutes.
// [RULE21] Delay above maximum time: alarm only forces full brightness, never the buzzer.
// [RULE22] Maximum alarm duration ranges 2 to 60 minutes.
// [RULE23] Alarm fires on armed, active day and time match; ends at maximum duration.
package clkmac_pkg;
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_ALARM  = 8'h04;
  localparam logic [7:0] ADDR_ALARM2 = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  // Field low bits
  localparam int CTRL_TEMP = 2, CTRL_BRT = 3, CTRL_ARM = 8;
  localparam int AL_MIN = 8, AL_SNZ = 16, AL_DLY = 24;
  localparam int AL2_DAY = 16, AL2_WEEK = 24, AL2_WKND = 25;
  localparam int ST_RING = 4, ST_SNZ = 5, ST_BUZ = 6, ST_FULL = 7, ST_DAY = 8;
  // Ranges and reset values
  localparam logic [5:0] MIN_MAX   = 6'h3B;
  localparam logic [4:0] HOUR_MAX  = 5'h17;
  localparam logic [4:0] SNZ_MIN   = 5'h01;
  localparam logic [4:0] SNZ_MAX   = 5'h1E;
  localparam logic [3:0] DLY_MAX   = 4'hA;
  localparam logic [5:0] MAXT_MIN  = 6'h02;
  localparam logic [5:0] MAXT_MAX  = 6'h3C;
  localparam logic [3:0] DAYS_LAST = 4'h6;
  localparam logic [3:0] SEL_WEEK  = 4'h7;
  localparam logic [3:0] SEL_WKND  = 4'h8;
  localparam logic [2:0] SAT_IDX   = 3'h5;
  localparam logic [4:0] BRT_RST   = 5'h0F;
  localparam logic [5:0] MAXT_RST  = 6'h1E;
  localparam logic [4:0] SNZ_RST   = 5'h05;
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned LONG_PRESS_MS = 1000;
  localparam int unsigned LONG_PRESS_CYC = LONG_PRESS_MS * (CLK_HZ / 1000);
  localparam logic [1:0] MODE_CLOCK_HIDDEN       = 2'h0;
  localparam logic [1:0] MODE_HOURS_MINUTES_ONLY = 2'h1;
  localparam logic [1:0] MODE_CALENDAR_ONLY      = 2'h2;
  localparam logic [1:0] MODE_ALTERNATING_VIEW   = 2'h3;
  typedef enum logic [3:0] {
    CM_CLOSED = 4'h0, CM_DISPMODE = 4'h1, CM_SHOWTEMP = 4'h2, CM_ALARM = 4'h3,
    CM_DAYSEL = 4'h4, CM_ENABLE = 4'h5, CM_HOUR = 4'h6, CM_MINUTE = 4'h7,
    CM_SNOOZE = 4'h8, CM_DELAY = 4'h9, CM_MAXTIME = 4'hA, CM_AEXIT = 4'hB,
    CM_MENUEND = 4'hC
  } clkmac_menu_t;
  typedef enum logic [2:0] {
    VIEW_BLANK = 3'h0, VIEW_TIME = 3'h1, VIEW_DATE = 3'h2, VIEW_TEMP = 3'h3,
    VIEW_DASHES = 3'h4, VIEW_MENU = 3'h5, VIEW_SYNC = 3'h6
  } clkmac_view_t;
  typedef enum logic [1:0] {
    AL_IDLE = 2'h0, AL_RING = 2'h1, AL_SNOOZE = 2'h2
  } clkmac_alarm_t;
endpackage

// *** tb/clkmac_keys.sv ***
`timescale 1ns/1ns
`default_nettype none
// ********
// Push-button user and calibration-start watcher
// ********
module clkmac_keys (
  input  wire logic mclk,
  input  wire logic calTempStart,
  input  wire logic calOffsetStart,
  output logic      keyFwdPin,
  output logic      keyBackPin,
  output logic      keyPlusPin,
  output logic      keyMinusPin,
  output int        calTempSeen,
  output int        calOffsetSeen
);
  logic [3:0] keys = 4'h0;
  int         tCnt = 0;
  int         oCnt = 0;
  assign {keyMinusPin, keyPlusPin, keyBackPin, keyFwdPin} = keys;
  assign calTempSeen = tCnt;
  assign calOffsetSeen = oCnt;
  always @(posedge mclk) begin
    if (calTempStart === 1'b1) tCnt <= tCnt + 1;
    if (calOffsetStart === 1'b1) oCnt <= oCnt + 1;
  end
  // Quiet gap lets the synchronisers see a clean release
  task automatic press(input int k, input int n);
    keys[k] <= 1'b1;
    repeat (n) @(posedge mclk);
    keys[k] <= 1'b0;
    repeat (10) @(posedge mclk);
  endtask
endmodule // clkmac_keys
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin errTotal++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module testbench;
  import clkmac_pkg::*;
  localparam int KF = 0, KB = 1, KP = 2, KM = 3;
  logic mclk = 1'b0, reset_n = 1'b0, hsel = 1'b1, hwrite = 1'b0, hreadyout, hresp;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2, curWeekday = 3'h0;
  logic [4:0] curHour = 5'h00;
  logic [5:0] curMinute = 6'h00;
  logic minuteTick = 1'b0, altTick = 1'b0, syncActive = 1'b0, rxSignal = 1'b0, tempOk = 1'b0;
  logic keyFwdPin, keyBackPin, keyPlusPin, keyMinusPin, fullBright, buzzer, dpOn;
  logic calTempStart, calOffsetStart;
  clkmac_view_t viewSel, v0, v1;
  clkmac_menu_t menuItem;
  int errTotal = 0, comparisons = 0, calTempSeen, calOffsetSeen;
  always #50 mclk = ~mclk;
  // Short hold count keeps long presses cheap
  clkmac_top #(.LONG_CYC(20)) u_dut (.mclk(mclk), .reset_n(reset_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .keyFwdPin(keyFwdPin), .keyBackPin(keyBackPin), .keyPlusPin(keyPlusPin),
    .keyMinusPin(keyMinusPin), .curHour(curHour), .curMinute(curMinute),
    .curWeekday(curWeekday), .minuteTick(minuteTick), .altTick(altTick),
    .syncActive(syncActive), .rxSignal(rxSignal), .tempOk(tempOk), .viewSel(viewSel),
    .dpOn(dpOn), .menuItem(menuItem), .fullBright(fullBright), .buzzer(buzzer),
    .calTempStart(calTempStart), .calOffsetStart(calOffsetStart));
  clkmac_keys u_keys (.mclk(mclk), .calTempStart(calTempStart),
    .calOffsetStart(calOffsetStart), .keyFwdPin(keyFwdPin), .keyBackPin(keyBackPin),
    .keyPlusPin(keyPlusPin), .keyMinusPin(keyMinusPin), .calTempSeen(calTempSeen),
    .calOffsetSeen(calOffsetSeen));
  // ********
  // Helpers
  // ********
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    `CHK(q & m, e)
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic tick(input logic [5:0] m);
    curMinute <= m;
    @(posedge mclk);
    minuteTick <= 1'b1;
    @(posedge mclk);
    minuteTick <= 1'b0;
    cyc(3);
  endtask
  task automatic alt();
    altTick <= 1'b1;
    @(posedge mclk);
    altTick <= 1'b0;
    cyc(3);
  endtask
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", comparisons, errTotal);
    if (errTotal == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    cyc(20000);
    errTotal++;
    complete_run();
  end
  // ********
  // Tests
  // ********
  initial begin
    cyc(12);
    reset_n <= 1'b1;
    @(posedge mclk);
    rdchk(ADDR_CTRL, 32'hFFFFFFFF, 32'h0000007B);
    rdchk(ADDR_ALARM, 32'hFFFFFFFF, 32'h00050000);
    rdchk(ADDR_ALARM2, 32'hFFFFFFFF, 32'h0000001E);
    bus(8'h10, 1'b1, 32'hFFFFFFFF);
    rdchk(8'h10, 32'hFFFFFFFF, 32'h0);
    $display("reset test done");
    syncActive <= 1'b1;
    cyc(4);
    `CHK(viewSel, VIEW_SYNC)
    bus(ADDR_CTRL, 1'b1, 32'h3);
    rxSignal <= 1'b1;
    cyc(5);
    `CHK(viewSel, VIEW_BLANK)
    `CHK(dpOn, 1'b1)
    rxSignal <= 1'b0;
    syncActive <= 1'b0;
    $display("sync test done");
    u_keys.press(KP, 6);
    rdchk(ADDR_CTRL, 32'h100, 32'h100);
    u_keys.press(KP, 6);
    rdchk(ADDR_CTRL, 32'h100, 32'h0);
    u_keys.press(KM, 6);
    `CHK(fullBright, 1'b1)
    u_keys.press(KM, 6);
    `CHK(fullBright, 1'b0)
    bus(ADDR_CTRL, 1'b1, 32'h0);
    cyc(3);
    `CHK(viewSel, VIEW_DASHES)
    bus(ADDR_CTRL, 1'b1, 32'h4);
    tempOk <= 1'b1;
    cyc(3);
    `CHK(viewSel, VIEW_TEMP)
    bus(ADDR_CTRL, 1'b1, 32'h5);
    alt();
    v0 = viewSel;
    alt();
    v1 = viewSel;
    `CHK({v0, v1} == {VIEW_TIME, VIEW_TEMP} || {v0, v1} == {VIEW_TEMP, VIEW_TIME}, 1'b1)
    bus(ADDR_CTRL, 1'b1, 32'h2);
    alt();
    `CHK(viewSel, VIEW_DATE)
    $display("normal mode test done");
    bus(ADDR_CTRL, 1'b1, 32'h3);
    u_keys.press(KF, 6);
    `CHK(menuItem, CM_DISPMODE)
    for (int i = 0; i < 4; i++) begin
      u_keys.press(KP, 6);
      rdchk(ADDR_CTRL, 32'h3, 32'(i));
    end
    u_keys.press(KM, 6);
    rdchk(ADDR_CTRL, 32'h3, 32'h2);
    u_keys.press(KF, 6);
    u_keys.press(KB, 6);
    `CHK(menuItem, CM_DISPMODE)
    u_keys.press(KF, 6);
    u_keys.press(KP, 6);
    rdchk(ADDR_CTRL, 32'h4, 32'h4);
    u_keys.press(KM, 6);
    rdchk(ADDR_CTRL, 32'h4, 32'h0);
    u_keys.press(KP, 25);
    `CHK(calTempSeen, 1)
    rdchk(ADDR_CTRL, 32'h4, 32'h0);
    u_keys.press(KM, 25);
    `CHK(calOffsetSeen, 1)
    u_keys.press(KF, 6);
    u_keys.press(KP, 6);
    `CHK(menuItem, CM_DAYSEL)
    u_keys.press(KP, 25);
    rdchk(ADDR_ALARM2, 32'h10000, 32'h10000);
    `CHK(dpOn, 1'b1)
    repeat (2) u_keys.press(KM, 6);
    u_keys.press(KP, 25);
    repeat (2) u_keys.press(KP, 6);
    u_keys.press(KM, 25);
    rdchk(ADDR_ALARM2, 32'h01010000, 32'h01010000);
    u_keys.press(KF, 6);
    u_keys.press(KP, 6);
    rdchk(ADDR_CTRL, 32'h100, 32'h100);
    u_keys.press(KM, 6);
    rdchk(ADDR_CTRL, 32'h100, 32'h0);
    bus(ADDR_ALARM, 1'b1, 32'h00013B00);
    repeat (2) u_keys.press(KF, 6);
    u_keys.press(KP, 6);
    rdchk(ADDR_ALARM, 32'h3F00, 32'h3B00);
    u_keys.press(KM, 6);
    rdchk(ADDR_ALARM, 32'h3F00, 32'h3A00);
    u_keys.press(KF, 6);
    u_keys.press(KM, 6);
    rdchk(ADDR_ALARM, 32'h001F0000, 32'h00010000);
    u_keys.press(KF, 6);
    u_keys.press(KM, 6);
    rdchk(ADDR_ALARM, 32'h0F000000, 32'h0);
    u_keys.press(KP, 6);
    rdchk(ADDR_ALARM, 32'h0F000000, 32'h01000000);
    repeat (2) u_keys.press(KF, 6);
    `CHK(menuItem, CM_AEXIT)
    u_keys.press(KP, 6);
    `CHK(menuItem, CM_ALARM)
    repeat (3) u_keys.press(KB, 6);
    `CHK(menuItem, CM_CLOSED)
    $display("menu test done");
    bus(ADDR_ALARM, 1'b1, 32'h00051E07);
    bus(ADDR_ALARM2, 1'b1, 32'h00010002);
    bus(ADDR_CTRL, 1'b1, 32'h103);
    curHour <= 5'h07;
    tick(6'h1E);
    `CHK(buzzer, 1'b1)
    u_keys.press(KP, 6);
    rdchk(ADDR_STATUS, 32'h60, 32'h20);
    u_keys.press(KF, 6);
    rdchk(ADDR_STATUS, 32'h30, 32'h0);
    tick(6'h1E);
    tick(6'h1F);
    rdchk(ADDR_STATUS, 32'h10, 32'h10);
    tick(6'h20);
    rdchk(ADDR_STATUS, 32'h10, 32'h0);
    bus(ADDR_ALARM, 1'b1, 32'h05051E07);
    tick(6'h1E);
    `CHK(buzzer, 1'b0)
    `CHK(fullBright, 1'b1)
    u_keys.press(KB, 6);
    rdchk(ADDR_STATUS, 32'h30, 32'h0);
    $display("alarm test done");
    complete_run();
  end
endmodule // testbench
`default_nettype wire
